/* File: verilog/gci_pkg.sv */
// constants and carrier types for the frame interface command/indication block
`default_nettype none
package gci_pkg;
  // clock and link timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int DBC_HALF_NS = 122;
  localparam int DBC_HALF_CYC_INT = (DBC_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    DBC_HALF_NS / CLK_PERIOD_NS;
  localparam logic [4:0] DBC_HALF_LAST = 5'(DBC_HALF_CYC_INT - 1);
  // 32 slots x 8 bits x 2 bit clock periods (rising edges) per frame
  localparam logic [8:0] HALF_LAST = 9'h1ff;
  localparam logic [3:0] SLOT_START = 4'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // positions inside the selected four-byte group of the frame
  localparam logic [1:0] SLOT_B1 = 2'h0;
  localparam logic [1:0] SLOT_B2 = 2'h1;
  localparam logic [1:0] SLOT_MON = 2'h2;
  localparam logic [1:0] SLOT_CI = 2'h3;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [1:0] D_IDLE = 2'h3;
  localparam logic [1:0] CI_PAD = 2'h0;
  // routing codes of the data slots
  localparam logic [1:0] ROUT_ONE_OUT = 2'h2;
  localparam logic [1:0] ROUT_TWO_OUT = 2'h3;
  // receive buffer
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 32;

  typedef struct packed {
    logic frame_interface_enable;
    logic pcm_master_select;
    logic [2:0] frame_slot_group;
    logic wide_ci_select;
    logic tx_handshake_swap;
    logic rx_handshake_swap;
    logic serial_line_swap;
    logic indication_irq_mask;
    logic slot_direction;
    logic channel_direction;
    logic [1:0] pin_routing;
  } gci_cfg_t;

  // one driven pin: level driven and drive enable
  typedef struct packed {
    logic out;
    logic oe;
  } gci_pin_t;
endpackage
`default_nettype wire

/* File: verilog/gci_ci_channel.sv */
// frame timing, command/indication slot and receive buffer of the frame interface
`default_nettype none

module gci_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } gci_fifo_state_t;

  gci_fifo_state_t s_r;
  gci_fifo_state_t s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;

  assign full = (s_r.wr[AW] != s_r.rd[AW]) && (s_r.wr[AW-1:0] == s_r.rd[AW-1:0]);
  assign empty = (s_r.wr == s_r.rd);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[s_r.rd[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (in_valid && !full) begin
      s_nxt.wr = s_r.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // storage has no reset; only the pointers decide what is valid
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[s_r.wr[AW-1:0]] <= in_data;
    end
  end
endmodule // gci_fifo

module gci_ci_channel (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire gci_pkg::gci_cfg_t cfg,
  input wire logic [5:0] command_out_field,
  input wire logic [7:0] data_tx_byte,
  input wire logic monitor_transmit_handshake,
  input wire logic monitor_receive_ack,
  input wire logic event_clear,
  // status
  output logic [5:0] indication_in_field,
  output logic indication_change_event,
  output logic indication_irq,
  output logic rx_mx,
  output logic rx_mr,
  output logic rx_overrun,
  // received data slots
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [gci_pkg::FIFO_W-1:0] rx_data,
  // bus clocks
  input wire logic double_rate_bit_clock_in,
  output gci_pkg::gci_pin_t double_rate_bit_clock,
  input wire logic frame_sync_8khz_in,
  output gci_pkg::gci_pin_t frame_sync_8khz,
  // serial lines
  input wire logic serial_line_one_in,
  output gci_pkg::gci_pin_t serial_line_one,
  input wire logic serial_line_two_in,
  output gci_pkg::gci_pin_t serial_line_two
);
  typedef struct packed {
    logic [1:0] dbc_sync;
    logic [1:0] fs_sync;
    logic [1:0] l1_sync;
    logic [1:0] l2_sync;
    logic dbc_prev;
    logic [4:0] div;
    logic dbc_o;
    logic fs_o;
    logic dbc_oe;
    logic [8:0] half;
    logic [7:0] tx_byte;
    logic drv1;
    logic drv2;
    logic smp1;
    logic smp2;
    logic [7:0] rx_sh;
    logic [5:0] ind;
    logic ev;
    logic irq;
    logic mx;
    logic mr;
    logic push;
    logic [gci_pkg::FIFO_W-1:0] push_data;
    logic ovr;
    gci_pkg::gci_pin_t l1;
    gci_pkg::gci_pin_t l2;
  } gci_state_t;

  gci_state_t s_r;
  gci_state_t s_nxt;
  logic fifo_in_ready;
  logic master;
  logic tick;
  logic fs_seen;
  logic [8:0] half_nxt;
  logic [4:0] slot;
  logic in_frame;
  logic [1:0] rel;
  logic [2:0] bitp;
  logic [1:0] hs_tx;
  logic [7:0] ci_byte;
  logic [7:0] rx_byte;
  logic rx_bit;
  logic [5:0] ci_rx;
  logic data_tx;
  logic data_rx;
  logic ind_set;

  assign master = cfg.pcm_master_select;
  assign tick = master ? (s_r.div == gci_pkg::DBC_HALF_LAST && !s_r.dbc_o)
                       : (s_r.dbc_sync[1] && !s_r.dbc_prev);
  assign fs_seen = master ? (s_r.half == gci_pkg::HALF_LAST) : s_r.fs_sync[1];
  assign half_nxt = fs_seen ? '0 : 9'(s_r.half + 9'h001);
  assign slot = half_nxt[8:4];
  assign in_frame = (slot[4:2] == cfg.frame_slot_group);
  assign rel = slot[1:0];
  assign bitp = half_nxt[3:1];
  assign hs_tx = cfg.tx_handshake_swap ? {monitor_transmit_handshake, monitor_receive_ack}
                                       : {monitor_receive_ack, monitor_transmit_handshake};
  assign ci_byte = cfg.wide_ci_select ? {command_out_field, hs_tx}
                                      : {gci_pkg::D_IDLE, command_out_field[3:0], hs_tx};
  assign data_tx = !cfg.slot_direction && !cfg.channel_direction;
  assign data_rx = cfg.slot_direction && cfg.channel_direction;
  assign rx_bit = s_r.smp1 ? s_r.l1_sync[1] : s_r.l2_sync[1];
  assign rx_byte = {s_r.rx_sh[6:0], rx_bit};
  assign ci_rx = cfg.wide_ci_select ? rx_byte[7:2] : {gci_pkg::CI_PAD, rx_byte[5:2]};
  assign ind_set = tick && half_nxt[0] && bitp == gci_pkg::BIT_LAST && in_frame &&
                   rel == gci_pkg::SLOT_CI && (s_r.smp1 || s_r.smp2) && ci_rx != s_r.ind;

  always_comb begin
    s_nxt = s_r;
    s_nxt.dbc_sync = {s_r.dbc_sync[0], double_rate_bit_clock_in};
    s_nxt.fs_sync = {s_r.fs_sync[0], frame_sync_8khz_in};
    s_nxt.l1_sync = {s_r.l1_sync[0], serial_line_one_in};
    s_nxt.l2_sync = {s_r.l2_sync[0], serial_line_two_in};
    s_nxt.dbc_prev = s_r.dbc_sync[1];
    s_nxt.dbc_oe = master;
    s_nxt.push = 1'b0;
    if (master) begin
      if (s_r.div == gci_pkg::DBC_HALF_LAST) begin
        s_nxt.div = '0;
        s_nxt.dbc_o = !s_r.dbc_o;
      end else begin
        s_nxt.div = 5'(s_r.div + 5'h01);
      end
    end else begin
      s_nxt.div = '0;
      s_nxt.dbc_o = 1'b0;
      s_nxt.fs_o = 1'b0;
    end
    if (tick) begin
      s_nxt.half = half_nxt;
      s_nxt.fs_o = master && (half_nxt == gci_pkg::HALF_LAST);
      if (half_nxt[3:0] == gci_pkg::SLOT_START) begin
        s_nxt.drv1 = 1'b0;
        s_nxt.drv2 = 1'b0;
        s_nxt.smp1 = 1'b0;
        s_nxt.smp2 = 1'b0;
        s_nxt.tx_byte = gci_pkg::IDLE_BYTE;
        if (in_frame && cfg.frame_interface_enable &&
            (rel == gci_pkg::SLOT_MON || rel == gci_pkg::SLOT_CI)) begin
          s_nxt.drv1 = !cfg.serial_line_swap;
          s_nxt.drv2 = cfg.serial_line_swap;
          s_nxt.smp1 = cfg.serial_line_swap;
          s_nxt.smp2 = !cfg.serial_line_swap;
          s_nxt.tx_byte = (rel == gci_pkg::SLOT_MON) ? gci_pkg::IDLE_BYTE : ci_byte;
        end else if (in_frame && rel != gci_pkg::SLOT_MON) begin
          s_nxt.drv1 = data_tx && cfg.pin_routing == gci_pkg::ROUT_ONE_OUT;
          s_nxt.drv2 = data_tx && cfg.pin_routing == gci_pkg::ROUT_TWO_OUT;
          s_nxt.smp1 = data_rx && cfg.pin_routing == gci_pkg::ROUT_TWO_OUT;
          s_nxt.smp2 = data_rx && cfg.pin_routing == gci_pkg::ROUT_ONE_OUT;
          s_nxt.tx_byte = data_tx_byte;
        end
      end
      if (!half_nxt[0]) begin
        // msb first, changed on even edges
        s_nxt.l1.out = s_nxt.tx_byte[3'(gci_pkg::BIT_LAST - bitp)];
        s_nxt.l2.out = s_nxt.tx_byte[3'(gci_pkg::BIT_LAST - bitp)];
        s_nxt.l1.oe = s_nxt.drv1;
        s_nxt.l2.oe = s_nxt.drv2;
      end else begin
        // sampled mid-bit, away from the far end's transitions
        s_nxt.rx_sh = rx_byte;
        if (bitp == gci_pkg::BIT_LAST && in_frame && (s_r.smp1 || s_r.smp2)) begin
          if (rel == gci_pkg::SLOT_CI) begin
            s_nxt.ind = ci_rx;
            s_nxt.mr = cfg.rx_handshake_swap ? rx_byte[0] : rx_byte[1];
            s_nxt.mx = cfg.rx_handshake_swap ? rx_byte[1] : rx_byte[0];
          end else if (rel != gci_pkg::SLOT_MON) begin
            s_nxt.push = 1'b1;
            s_nxt.push_data = {rel == gci_pkg::SLOT_CI ? 1'b1 : rel[0], rx_byte};
          end
        end
      end
    end
    s_nxt.ev = (s_r.ev && !event_clear) || ind_set;
    s_nxt.irq = s_nxt.ev && cfg.indication_irq_mask;
    // link cannot stall, so a refused byte is counted as overrun
    s_nxt.ovr = (s_r.ovr && !event_clear) || (s_r.push && !fifo_in_ready);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  gci_fifo #(
    .WIDTH(gci_pkg::FIFO_W),
    .DEPTH(gci_pkg::FIFO_D)
  ) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(s_r.push),
    .in_ready(fifo_in_ready),
    .in_data(s_r.push_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign indication_in_field = s_r.ind;
  assign indication_change_event = s_r.ev;
  assign indication_irq = s_r.irq;
  assign rx_mx = s_r.mx;
  assign rx_mr = s_r.mr;
  assign rx_overrun = s_r.ovr;
  assign double_rate_bit_clock = '{out: s_r.dbc_o, oe: s_r.dbc_oe};
  assign frame_sync_8khz = '{out: s_r.fs_o, oe: s_r.dbc_oe};
  assign serial_line_one = s_r.l1;
  assign serial_line_two = s_r.l2;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  cmd_latch_a: assert property (tick && half_nxt[3:0] == gci_pkg::SLOT_START && in_frame &&
    rel == gci_pkg::SLOT_CI && cfg.frame_interface_enable && !cfg.wide_ci_select
    |=> s_r.tx_byte[5:2] == $past(command_out_field[3:0]))
    else $error("command not loaded into slot");
  ind_event_a: assert property (ind_set |=> s_r.ev && s_r.ind != $past(s_r.ind))
    else $error("indication change not flagged");
  irq_mask_a: assert property (s_r.irq |-> s_r.ev && $past(cfg.indication_irq_mask))
    else $error("irq without event or mask");
  off_silent_a: assert property (!cfg.frame_interface_enable &&
    tick && in_frame && rel == gci_pkg::SLOT_MON |=> !s_r.drv1 && !s_r.drv2)
    else $error("monitor slot driven while disabled");
  wrap_a: assert property (master && tick && s_r.half == gci_pkg::HALF_LAST
    |=> s_r.half == '0)
    else $error("frame counter did not wrap");
  line_swap_a: assert property (tick && half_nxt[3:0] == gci_pkg::SLOT_START && in_frame &&
    cfg.frame_interface_enable && rel == gci_pkg::SLOT_CI && cfg.serial_line_swap
    |=> s_r.drv2 && !s_r.drv1 && s_r.smp1)
    else $error("swap did not exchange lines");
  route_a: assert property (tick && half_nxt[3:0] == gci_pkg::SLOT_START && in_frame &&
    rel == gci_pkg::SLOT_B1 && data_tx && cfg.pin_routing == gci_pkg::ROUT_ONE_OUT
    |=> s_r.drv1 && !s_r.drv2 ##1 s_r.l1.oe)
    else $error("routing did not drive line one");
  slave_clk_a: assert property (!master [*3] |-> !s_r.dbc_o && !s_r.fs_o)
    else $error("slave drives bus clocks");
  overrun_a: assert property (s_r.push && !fifo_in_ready |=> s_r.ovr)
    else $error("dropped byte not reported");
endmodule // gci_ci_channel
`default_nettype wire

/* File: verilog/gci_fix_note.sv */
// intentionally empty
`default_nettype none
`default_nettype wire

/* File: dv/gci_partner.sv */
// behavioural far-side device: bus clocks, frame bytes, command slot capture
`default_nettype none
module gci_partner (
  // block pins
  input wire gci_pkg::gci_pin_t pin_one,
  input wire gci_pkg::gci_pin_t pin_two,
  // frame content
  input wire logic [2:0] grp,
  input wire logic wide,
  input wire logic [5:0] ind,
  input wire logic [1:0] hs,
  input wire logic [7:0] b1,
  input wire logic [7:0] b2,
  // bus clocks and resolved lines
  output logic lclk,
  output logic fsync,
  output logic line_one,
  output logic line_two,
  // captured command slot
  output logic [7:0] cap,
  output logic cap_two,
  output int cap_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] s1, s2, sh;
  logic d1, d2;
  int h, r;
  // the block wins wherever it drives
  assign line_one = pin_one.oe ? pin_one.out : d1;
  assign line_two = pin_two.oe ? pin_two.out : d2;
  initial begin
    {lclk, fsync, d1, d2, cap, cap_two, sh} = '0;
    h = 511;
    cap_cnt = 0;
    forever begin
      #62.5 lclk = 1'b1;
      h = (h + 1) % 512;
      r = h / 16 - 4 * int'(grp);
      if (h % 16 == 0) begin
        // foreign slots carry their frame position, the same value in every frame
        s1 = 8'(h);
        s2 = ~s1;
        if (r == 3) s1 = wide ? {ind, hs} : {gci_pkg::D_IDLE, ind[3:0], hs};
        if (r == 2) s1 = gci_pkg::IDLE_BYTE;
        if (r >= 2) s2 = s1;
        // inverse on line two exposes a wrong receive routing
        if (r == 0) s1 = b1;
        if (r == 1) s1 = b2;
        if (r == 0 || r == 1) s2 = ~s1;
      end
      if (h % 2 == 0) begin
        d1 = s1[7 - (h % 16) / 2];
        d2 = s2[7 - (h % 16) / 2];
      end else if (r == 3) begin
        sh = {sh[6:0], pin_two.oe ? pin_two.out : pin_one.out};
        if (h % 16 == 15) begin
          cap = sh;
          cap_two = pin_two.oe;
          cap_cnt++;
        end
      end
      #62.5 lclk = 1'b0;
      fsync = (h == 511);
    end
  end
endmodule // gci_partner
`default_nettype wire

/* File: dv/gci_ci_channel_tb.sv */
// self-checking bench of the command/indication channel and its buffer
`default_nettype none
module gci_ci_channel_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, rx_ready, event_clear, mtx, mrx;
  gci_pkg::gci_cfg_t cfg;
  logic [5:0] cmd, ind_f, p_ind;
  logic [7:0] tx_b, b1, b2, cap;
  logic [1:0] phs;
  logic ind_ev, ind_irq, rx_mx, rx_mr, rx_ovr, rx_valid;
  logic [8:0] rx_data;
  logic lclk, fsync, l1, l2, cap_two;
  gci_pkg::gci_pin_t dbc, fsy, so1, so2;
  int cap_cnt;
  int error_cnt = 0;
  int checks_done = 0;
  logic [8:0] rxq[$];

  gci_ci_channel gci_ci_channel_i (
    .clk(clk), .rst_n(rst_n), .cfg(cfg), .command_out_field(cmd), .data_tx_byte(tx_b),
    .monitor_transmit_handshake(mtx), .monitor_receive_ack(mrx), .event_clear(event_clear),
    .indication_in_field(ind_f), .indication_change_event(ind_ev), .indication_irq(ind_irq),
    .rx_mx(rx_mx), .rx_mr(rx_mr), .rx_overrun(rx_ovr),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .double_rate_bit_clock_in(dbc.oe ? dbc.out : lclk), .double_rate_bit_clock(dbc),
    .frame_sync_8khz_in(fsy.oe ? fsy.out : fsync), .frame_sync_8khz(fsy),
    .serial_line_one_in(l1), .serial_line_one(so1),
    .serial_line_two_in(l2), .serial_line_two(so2)
  );

  gci_partner gci_partner_i (
    .pin_one(so1), .pin_two(so2), .grp(cfg.frame_slot_group), .wide(cfg.wide_ci_select),
    .ind(p_ind), .hs(phs), .b1(b1), .b2(b2), .lclk(lclk), .fsync(fsync),
    .line_one(l1), .line_two(l2), .cap(cap), .cap_two(cap_two), .cap_cnt(cap_cnt)
  );

  always #4 clk = ~clk;

  always @(posedge clk) begin
    if (rx_valid && rx_ready) rxq.push_back(rx_data);
  end

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // end of the command slot, then let the block settle
  task automatic wait_cap();
    int c0;
    int n;
    c0 = cap_cnt;
    n = 0;
    while (cap_cnt == c0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 9000) begin
      error_cnt++;
      report_and_stop();
    end
    repeat (40) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    // ten frames of 64 us each plus margin
    #720us;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    int n, k;
    logic [5:0] fld, nf;
    logic [1:0] hs;
    logic ev, pv;
    logic [4:0] wd, cg, mk, ts, rs, ls;
    void'($urandom(32'h789a8409));
    // per step: wide, change, mask and the three swaps
    wd = 5'h18;
    cg = 5'h0e;
    mk = 5'h0b;
    ts = 5'h04;
    rs = 5'h08;
    ls = 5'h10;
    clk = 1'b0;
    rst_n = 1'b0;
    rx_ready = 1'b1;
    event_clear = 1'b0;
    cfg = '0;
    cfg.frame_slot_group = 3'($urandom);
    cfg.slot_direction = 1'b1;
    cfg.channel_direction = 1'b1;
    cfg.pin_routing = gci_pkg::ROUT_TWO_OUT;
    cmd = 6'($urandom);
    tx_b = 8'($urandom);
    {mtx, mrx, phs} = 4'($urandom);
    p_ind = 6'($urandom);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("reset", {ind_f, ind_ev, ind_irq, rx_valid}, 9'h000);
    // first frame lines the counter up with the far side's sync
    wait_cap();
    // buffer keeps two frames of data slots while nobody drains it
    rx_ready = 1'b0;
    rxq.delete();
    wait_cap();
    wait_cap();
    chk("fill", {rx_ovr, 7'h00, rx_valid}, 9'h001);
    for (k = 0; k < 300 && rxq.size() < 4; k++) begin
      rx_ready = 1'($urandom);
      @(negedge clk);
    end
    rx_ready = 1'b1;
    for (n = 0; n < 4 && n < rxq.size(); n++) begin
      chk("drain", rxq[n], {n[0], n[0] ? b2 : b1});
    end
    chk("empty", {rx_ovr, 7'(rxq.size()), rx_valid}, 9'h008);
    cfg.frame_interface_enable = 1'b1;
    wait_cap();
    fld = {2'b00, p_ind[3:0]};
    chk("field", 9'(ind_f), 9'(fld));
    for (k = 0; k < 5; k++) begin
      cfg.wide_ci_select = wd[k];
      cfg.tx_handshake_swap = ts[k];
      cfg.rx_handshake_swap = rs[k];
      cfg.serial_line_swap = ls[k];
      cfg.indication_irq_mask = mk[k];
      if (k != 1) cmd = 6'($urandom);
      if (cg[k]) p_ind = p_ind ^ {2'($urandom), 4'h5};
      {mtx, mrx, phs} = 4'($urandom);
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      rxq.delete();
      event_clear = 1'b1;
      @(negedge clk);
      event_clear = 1'b0;
      wait_cap();
      nf = wd[k] ? p_ind : {2'b00, p_ind[3:0]};
      ev = (nf != fld);
      fld = nf;
      hs = ts[k] ? {mtx, mrx} : {mrx, mtx};
      chk("cmd", 9'(cap), wd[k] ? 9'({cmd, hs}) : 9'({gci_pkg::D_IDLE, cmd[3:0], hs}));
      chk("line", 9'(cap_two), 9'(ls[k]));
      chk("field", 9'(ind_f), 9'(fld));
      chk("event", 9'(ind_ev), 9'(ev));
      chk("irq", 9'(ind_irq), 9'(ev & mk[k]));
      chk("hs rx", 9'({rx_mr, rx_mx}), rs[k] ? 9'({phs[0], phs[1]}) : 9'(phs));
      chk("rx cnt", {rx_ovr, 8'(rxq.size())}, 9'h002);
      for (n = 0; n < 2 && n < rxq.size(); n++) begin
        chk("rx data", rxq[n], {n[0], n[0] ? b2 : b1});
      end
    end
    // transmit direction drives line one, nothing received
    cfg.slot_direction = 1'b0;
    cfg.channel_direction = 1'b0;
    cfg.pin_routing = gci_pkg::ROUT_ONE_OUT;
    rxq.delete();
    wait_cap();
    chk("tx route", {rx_ovr, 7'(rxq.size()), rx_valid}, 9'h000);
    chk("slave clk", {7'h00, dbc.oe, fsy.out}, 9'h000);
    cfg.pcm_master_select = 1'b1;
    repeat (40) @(negedge clk);
    chk("clk oe", {7'h00, dbc.oe, fsy.oe}, 9'h003);
    n = 0;
    pv = dbc.out;
    for (k = 0; k < 300; k++) begin
      @(negedge clk);
      if (dbc.out && !pv) n++;
      pv = dbc.out;
    end
    chk("clk rate", 9'(n >= 9 && n <= 11), 9'h001);
    report_and_stop();
  end
endmodule // gci_ci_channel_tb
`default_nettype wire
